/* src/cis_pkg.sv */
// shared constants and carrier types for the core instruction subset block
package cis_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [7:0] WATCHDOG_CLEAR_VALUE = 8'h00;
  localparam logic [7:0] W_RESET_VALUE = 8'h00;
  localparam logic       TIMEOUT_RESET_VALUE = 1'b1;
  localparam logic       POWERDOWN_RESET_VALUE = 1'b1;
  localparam int NIB_LO_LSB = 0;
  localparam int NIB_HI_LSB = 4;
  localparam int NIB_W = 4;
  localparam logic [7:0] LIT_MAX = 8'hFF;

  // operation selector
  typedef enum logic [2:0] {
    CIS_OP_NONE,
    CIS_OP_LITERAL_MINUS_WORK,
    CIS_OP_NIBBLE_EXCHANGE,
    CIS_OP_XOR_LITERAL,
    CIS_OP_XOR_FILE,
    CIS_OP_SLEEP
  } cis_op_e;

  // one instruction issued to the block
  typedef struct packed {
    cis_op_e           op;
    logic [7:0]        literal;
    logic [ADDR_W-1:0] file_addr;
    logic              dest_file;
  } cis_instr_s;

  // arithmetic flags
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } cis_flags_s;

  // file register write-back
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } cis_fwrite_s;

endpackage : cis_pkg

/* src/cis_alu.sv */
// combinational datapath for the instruction subset
`timescale 1ns/1ps
`default_nettype none
module cis_alu (
  // operation and operands
  input  wire cis_pkg::cis_op_e op,
  input  wire logic [7:0]       work,
  input  wire logic [7:0]       literal,
  input  wire logic [7:0]       file_data,
  // results
  output logic [7:0]            result,
  output logic                  carry,
  output logic                  digit_carry,
  output logic                  zero
);

  logic [8:0] diff;
  logic [4:0] ndiff;

  // literal minus work: no borrow means carry set
  assign diff  = {1'b0, literal} + {1'b0, ~work} + 9'h001;
  assign ndiff = {1'b0, literal[3:0]} + {1'b0, ~work[3:0]} + 5'h01;

  // result selection
  always_comb begin
    unique case (op)
      cis_pkg::CIS_OP_LITERAL_MINUS_WORK: result = diff[7:0];
      cis_pkg::CIS_OP_NIBBLE_EXCHANGE:    result = {file_data[3:0], file_data[7:4]};
      cis_pkg::CIS_OP_XOR_LITERAL:        result = work ^ literal;
      cis_pkg::CIS_OP_XOR_FILE:           result = work ^ file_data;
      default:                            result = work;
    endcase
  end

  assign carry       = diff[8];
  assign digit_carry = ndiff[4];
  assign zero        = (result == 8'h00);

endmodule : cis_alu
`default_nettype wire

/* src/cis_core.sv */
// execution unit for subtract, swap, xor and sleep instructions
`timescale 1ns/1ps
`default_nettype none
module cis_core #(
  parameter int ADDR_W = cis_pkg::ADDR_W,
  parameter int PRESC_W = 8
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // instruction issue
  input  wire logic                instr_valid,
  input  wire cis_pkg::cis_instr_s instr,
  input  wire logic [7:0]          file_rdata,
  // wake from sleep
  input  wire logic                wake,
  // watchdog tick
  input  wire logic                watchdog_tick,
  // state
  output logic [7:0]               work_reg,
  output cis_pkg::cis_flags_s      flags,
  output logic                     timeout_flag,
  output logic                     powerdown_flag,
  output logic [7:0]               watchdog_counter,
  output logic [PRESC_W-1:0]       watchdog_prescaler,
  output logic                     sleeping,
  output logic                     osc_run,
  output cis_pkg::cis_fwrite_s     fwrite,
  output logic                     instr_ready
);

  // refuse parameter values the logic cannot serve
  if (ADDR_W != cis_pkg::ADDR_W) begin : g_bad_addr_w
    $error("file address must be 7 bits");
  end
  if (PRESC_W < 1) begin : g_bad_presc_w
    $error("prescaler width must be positive");
  end

  logic [7:0] result;
  logic       c_new;
  logic       digit_new;
  logic       z_new;
  logic       take;
  logic       is_sleep;

  assign take        = instr_valid && !sleeping;
  assign is_sleep    = take && (instr.op == cis_pkg::CIS_OP_SLEEP);
  assign instr_ready = !sleeping;
  assign osc_run     = !sleeping;

  cis_alu u_alu (
    .op          (instr.op),
    .work        (work_reg),
    .literal     (instr.literal),
    .file_data   (file_rdata),
    .result      (result),
    .carry       (c_new),
    .digit_carry (digit_new),
    .zero        (z_new)
  );

  // work register destination
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      work_reg <= cis_pkg::W_RESET_VALUE;
    end else if (take) begin
      unique case (instr.op)
        cis_pkg::CIS_OP_LITERAL_MINUS_WORK, cis_pkg::CIS_OP_XOR_LITERAL: work_reg <= result;
        cis_pkg::CIS_OP_NIBBLE_EXCHANGE: if (!instr.dest_file) work_reg <= result;
        cis_pkg::CIS_OP_XOR_FILE:        if (!instr.dest_file) work_reg <= result;
        default: ;
      endcase
    end
  end

  // file register write-back
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fwrite <= '0;
    end else begin
      fwrite.en   <= take && instr.dest_file &&
                     (instr.op == cis_pkg::CIS_OP_NIBBLE_EXCHANGE ||
                      instr.op == cis_pkg::CIS_OP_XOR_FILE);
      fwrite.addr <= instr.file_addr;
      fwrite.data <= result;
    end
  end

  // arithmetic flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else if (take) begin
      unique case (instr.op)
        cis_pkg::CIS_OP_LITERAL_MINUS_WORK: begin
          flags.carry            <= c_new;
          flags.digit_carry_flag <= digit_new;
          flags.zero             <= z_new;
        end
        cis_pkg::CIS_OP_XOR_LITERAL, cis_pkg::CIS_OP_XOR_FILE: flags.zero <= z_new;
        default: ; // swap leaves flags unchanged
      endcase
    end
  end

  // power flags: reset state is power-on (both set)
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag   <= cis_pkg::TIMEOUT_RESET_VALUE;
      powerdown_flag <= cis_pkg::POWERDOWN_RESET_VALUE;
    end else if (is_sleep) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
  end

  // watchdog counter and prescaler
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter   <= cis_pkg::WATCHDOG_CLEAR_VALUE;
      watchdog_prescaler <= '0;
    end else if (is_sleep) begin
      watchdog_counter   <= cis_pkg::WATCHDOG_CLEAR_VALUE;
      watchdog_prescaler <= '0;
    end else if (watchdog_tick) begin
      watchdog_prescaler <= watchdog_prescaler + 1'b1;
      if (&watchdog_prescaler) watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  // sleep state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleeping <= 1'b0;
    end else if (is_sleep) begin
      sleeping <= 1'b1;
    end else if (wake) begin
      sleeping <= 1'b0;
    end
  end

  property p_sleep_flags;
    @(posedge clk_sys) disable iff (!rst_n)
    is_sleep |=> (timeout_flag && !powerdown_flag && watchdog_counter == 8'h00 && watchdog_prescaler == '0);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep did not update flags");

  property p_sleep_halt;
    @(posedge clk_sys) disable iff (!rst_n)
    is_sleep |=> (sleeping && !osc_run && !instr_ready);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("core not halted after sleep");

  property p_sub_value;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_LITERAL_MINUS_WORK)
      |=> work_reg == 8'($past(instr.literal) - $past(work_reg));
  endproperty
  a_sub_value: assert property (p_sub_value) else $error("subtract result wrong");

  property p_sub_carry;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_LITERAL_MINUS_WORK)
      |=> (flags.carry == ($past(work_reg) <= $past(instr.literal))) &&
          (flags.digit_carry_flag == ($past(work_reg[3:0]) <= $past(instr.literal[3:0])));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

  property p_swap_flags;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_NIBBLE_EXCHANGE) |=> $stable(flags);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags");

  property p_swap_dest;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_NIBBLE_EXCHANGE && instr.dest_file)
      |=> fwrite.en && fwrite.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(work_reg);
  endproperty
  a_swap_dest: assert property (p_swap_dest) else $error("swap file write wrong");

  property p_xorl;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_XOR_LITERAL)
      |=> work_reg == ($past(work_reg) ^ $past(instr.literal)) && $stable(flags.carry);
  endproperty
  a_xorl: assert property (p_xorl) else $error("xor literal wrong");

  property p_xorf_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_XOR_FILE && instr.dest_file)
      |=> fwrite.en && fwrite.addr == $past(instr.file_addr) && $stable(flags.digit_carry_flag);
  endproperty
  a_xorf_addr: assert property (p_xorf_addr) else $error("xor file write wrong");

  property p_xorf_w;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_XOR_FILE && !instr.dest_file)
      |=> !fwrite.en && work_reg == ($past(work_reg) ^ $past(file_rdata));
  endproperty
  a_xorf_w: assert property (p_xorf_w) else $error("xor file to work wrong");

  property p_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_XOR_LITERAL) |=> flags.zero == (work_reg == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  // an instruction offered while asleep leaves the work register and flags alone and writes no file register
  property p_asleep_refuse;
    @(posedge clk_sys) disable iff (!rst_n)
    (sleeping && instr_valid) |=> $stable(work_reg) && $stable(flags) && !fwrite.en;
  endproperty
  a_asleep_refuse: assert property (p_asleep_refuse) else $error("instruction taken while asleep");

  property p_sub_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_LITERAL_MINUS_WORK) |=> flags.zero == (work_reg == 8'h00);
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("subtract zero flag wrong");

  // xor of two equal bytes is the only way to a zero result
  property p_xorf_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    (take && instr.op == cis_pkg::CIS_OP_XOR_FILE)
      |=> flags.zero == ($past(work_reg) == $past(file_rdata)) && $stable(flags.carry);
  endproperty
  a_xorf_zero: assert property (p_xorf_zero) else $error("xor file zero flag wrong");

endmodule : cis_core
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the core instruction subset execution unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  // one instruction and the state it should leave behind
  typedef struct {
    cis_pkg::cis_op_e op;
    logic [7:0] lit; logic [6:0] addr; logic dest; logic [7:0] fd;
    logic [7:0] w; logic c; logic dig; logic z; logic fen; logic [7:0] fdat;
  } cis_row_s;
  logic                 clk_sys;
  logic                 rst_n;
  logic                 instr_valid;
  cis_pkg::cis_instr_s  instr;
  logic [7:0]           file_rdata;
  logic                 wake;
  logic                 watchdog_tick;
  logic [7:0]           work_reg;
  cis_pkg::cis_flags_s  flags;
  logic                 timeout_flag;
  logic                 powerdown_flag;
  logic [7:0]           watchdog_counter;
  logic [7:0]           watchdog_prescaler;
  logic                 sleeping;
  logic                 osc_run;
  cis_pkg::cis_fwrite_s fwrite;
  logic                 instr_ready;
  int                   num_errors = 0;
  int                   n_checks = 0;
  // chained rows: each starts from the work value the previous one left
  cis_row_s rows [0:12] = '{
    '{cis_pkg::CIS_OP_LITERAL_MINUS_WORK, 8'h05, 7'h00, 1'b0, 8'h00, 8'h05, 1, 1, 0, 0, 8'h00},
    '{cis_pkg::CIS_OP_LITERAL_MINUS_WORK, 8'h03, 7'h00, 1'b0, 8'h00, 8'hFE, 0, 0, 0, 0, 8'h00},
    '{cis_pkg::CIS_OP_XOR_LITERAL,        8'hFE, 7'h00, 1'b0, 8'h00, 8'h00, 0, 0, 1, 0, 8'h00},
    '{cis_pkg::CIS_OP_LITERAL_MINUS_WORK, 8'h00, 7'h00, 1'b0, 8'h00, 8'h00, 1, 1, 1, 0, 8'h00},
    '{cis_pkg::CIS_OP_XOR_LITERAL,        8'hA5, 7'h00, 1'b0, 8'h00, 8'hA5, 1, 1, 0, 0, 8'h00},
    '{cis_pkg::CIS_OP_NIBBLE_EXCHANGE,    8'h00, 7'h11, 1'b0, 8'h3C, 8'hC3, 1, 1, 0, 0, 8'h00},
    '{cis_pkg::CIS_OP_NIBBLE_EXCHANGE,    8'h00, 7'h22, 1'b0, 8'h00, 8'h00, 1, 1, 0, 0, 8'h00},
    '{cis_pkg::CIS_OP_NIBBLE_EXCHANGE,    8'h00, 7'h7F, 1'b1, 8'h12, 8'h00, 1, 1, 0, 1, 8'h21},
    '{cis_pkg::CIS_OP_XOR_FILE,           8'h00, 7'h00, 1'b0, 8'h5A, 8'h5A, 1, 1, 0, 0, 8'h00},
    '{cis_pkg::CIS_OP_XOR_FILE,           8'h00, 7'h40, 1'b1, 8'h5A, 8'h5A, 1, 1, 1, 1, 8'h00},
    '{cis_pkg::CIS_OP_LITERAL_MINUS_WORK, 8'h5A, 7'h00, 1'b0, 8'h00, 8'h00, 1, 1, 1, 0, 8'h00},
    '{cis_pkg::CIS_OP_LITERAL_MINUS_WORK, 8'h10, 7'h00, 1'b0, 8'h00, 8'h10, 1, 1, 0, 0, 8'h00},
    '{cis_pkg::CIS_OP_LITERAL_MINUS_WORK, 8'h0F, 7'h00, 1'b0, 8'h00, 8'hFF, 0, 1, 0, 0, 8'h00}};

  cis_core u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .wake(wake), .watchdog_tick(watchdog_tick), .work_reg(work_reg),
    .flags(flags), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .watchdog_counter(watchdog_counter), .watchdog_prescaler(watchdog_prescaler), .sleeping(sleeping),
    .osc_run(osc_run), .fwrite(fwrite), .instr_ready(instr_ready)
  );

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // compare one value and count it
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  // one clock, then let the edge's updates settle
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  // present one instruction
  task automatic drive(input cis_pkg::cis_op_e op, input logic [7:0] lit, input logic [6:0] a,
                       input logic d, input logic [7:0] fd);
    instr_valid = 1'b1;
    instr       = '{op, lit, a, d};
    file_rdata  = fd;
  endtask : drive

  // print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    rst_n = 1'b0; instr_valid = 1'b0; instr = '0; file_rdata = 8'h00; wake = 1'b0; watchdog_tick = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk("work", 8'h00, work_reg);
    chk("timeout", 8'h01, {7'h00, timeout_flag});
    chk("powerdown", 8'h01, {7'h00, powerdown_flag});
    // ordinary cases back to back, one per cycle
    foreach (rows[i]) begin
      drive(rows[i].op, rows[i].lit, rows[i].addr, rows[i].dest, rows[i].fd);
      step();
      chk("work", rows[i].w, work_reg);
      chk("flags", {5'h00, rows[i].c, rows[i].dig, rows[i].z}, {5'h00, flags});
      chk("fwrite_en", {7'h00, rows[i].fen}, {7'h00, fwrite.en});
      if (rows[i].fen) chk("fwrite_data", rows[i].fdat, fwrite.data);
      if (rows[i].fen) chk("fwrite_addr", {1'b0, rows[i].addr}, {1'b0, fwrite.addr});
    end
    instr_valid = 1'b0;
    // run the watchdog up, then sleep
    watchdog_tick = 1'b1;
    repeat (300) step();
    // 300 ticks: one carry out of the 8-bit prescaler, 44 left over
    chk("watchdog_run", 8'h01, watchdog_counter);
    chk("prescaler_run", 8'h2C, watchdog_prescaler);
    watchdog_tick = 1'b0;
    drive(cis_pkg::CIS_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00);
    step();
    instr_valid = 1'b0;
    chk("watchdog", 8'h00, watchdog_counter);
    chk("prescaler", 8'h00, watchdog_prescaler);
    chk("timeout", 8'h01, {7'h00, timeout_flag});
    chk("powerdown", 8'h00, {7'h00, powerdown_flag});
    chk("sleep_state", 8'h02, {6'h00, sleeping, osc_run});
    // an instruction while asleep is refused
    drive(cis_pkg::CIS_OP_XOR_LITERAL, 8'hFF, 7'h00, 1'b0, 8'h00);
    step();
    instr_valid = 1'b0;
    chk("work_asleep", 8'hFF, work_reg);
    chk("ready_asleep", 8'h00, {7'h00, instr_ready});
    wake = 1'b1;
    step();
    wake = 1'b0;
    chk("awake_state", 8'h01, {6'h00, sleeping, osc_run});
    chk("ready_awake", 8'h01, {7'h00, instr_ready});
    drive(cis_pkg::CIS_OP_XOR_LITERAL, 8'hFF, 7'h00, 1'b0, 8'h00);
    step();
    instr_valid = 1'b0;
    chk("work_awake", 8'h00, work_reg);
    chk("zero_awake", 8'h01, {7'h00, flags.zero});
    // second reset in mid-run acts at once
    rst_n = 1'b0;
    #2;
    chk("work_rst", 8'h00, work_reg);
    chk("flags_rst", 8'h03, {6'h00, timeout_flag, powerdown_flag});
    chk("arith_rst", 8'h00, {5'h00, flags});
    chk("fwen_rst", 8'h00, {7'h00, fwrite.en});
    step();
    rst_n = 1'b1;
    // the first edge after release already takes an instruction
    drive(cis_pkg::CIS_OP_XOR_LITERAL, 8'h3C, 7'h00, 1'b0, 8'h00);
    step();
    instr_valid = 1'b0;
    chk("work_after_rst", 8'h3C, work_reg);
    chk("flags_after_rst", 8'h00, {5'h00, flags});
    step();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
